// ### core/dic_input_conditioner.sv
// Operation
// - Eight isolated channels, two groups of four, each group on one return.
// - Every channel is sampled and updated once per 5 ms program cycle.
// - Polarity 0 reads energized as 1, polarity 1 reads it as 0; default 0.
// - Normally open: voltage above on level activates; 0.1 V steps, 88 V default.
// - Normally closed: voltage above on level deactivates.
// - Normally open: voltage below off level deactivates; default 60 V.
// - Normally closed: voltage below off level activates.
// - Each 0-to-1 change waits the activation delay, 1 ms steps, default zero.
// - Each 1-to-0 change waits the drop-off delay, 1 ms steps, default zero.
// - Alternating supply option adds a fixed 30 ms deactivation delay.
// - With that option the off level is 10 percent of the on level.
// - Each channel counts its 0-to-1 changes in 32 bits from zero.
// - Writing 1 to a channel's clear setting zeroes its counter; 0 does nothing.
// - Each channel's present voltage is readable in 1 mV units.
// - Every channel has its own on and off levels.
// - Channel numbers follow the inputs of preceding modules by a settable base.
//
// The address map and the address-and-strobe port were chosen for this implementation.
module dic_input_conditioner
   import dic_pkg::*;
#(
   parameter int NCH = NUM_CH,
   parameter int MS_CNT = MS_CLKS,
   parameter int CYC_MS = PROG_CYCLE_MS
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [NCH*V_W-1:0] input_channel_n_mv,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   output logic [NCH-1:0] input_channel_n
);

   // Threshold in steps of 0.1 V converted to millivolts
   function automatic logic [V_W-1:0] lvl_to_mv(input logic [LVL_W-1:0] lvl);
      lvl_to_mv = V_W'(lvl * LVL_MV_PER_STEP);
   endfunction

   // Off level forced to a fraction of the on level
   function automatic logic [V_W-1:0] ac_off_mv(input logic [LVL_W-1:0] lvl);
      ac_off_mv = V_W'(lvl * LVL_MV_PER_STEP * AC_OFF_PCT / 100);
   endfunction

   function automatic logic is_chan(input logic [ADDR_W-1:0] a);
      is_chan = (a & GLOBAL_BIT) == '0;
   endfunction

   function automatic logic [2:0] ch_of(input logic [ADDR_W-1:0] a);
      ch_of = a[CH_LSB +: 3];
   endfunction

   function automatic logic [2:0] fld_of(input logic [ADDR_W-1:0] a);
      fld_of = a[FLD_LSB +: 3];
   endfunction

   logic ms_tick;
   logic cycle_tick;

   logic [NCH-1:0] pol_q;
   logic [NCH-1:0] ac_q;
   logic [LVL_W-1:0] on_lvl_q [NCH];
   logic [LVL_W-1:0] off_lvl_q [NCH];
   logic [DLY_W-1:0] on_dly_q [NCH];
   logic [DLY_W-1:0] off_dly_q [NCH];
   logic [CNT_W-1:0] count_q [NCH];
   logic [V_W-1:0] volt_q [NCH];
   logic [NCH-1:0] energ_q;
   logic [DLY_W:0] pend_q [NCH];
   dic_state_t state_q [NCH];
   logic [BASE_W-1:0] chan_base_q;

   logic [NCH-1:0] energ_d;
   logic [NCH-1:0] tgt_d;
   logic [NCH-1:0] go_on;
   logic [NCH-1:0] go_off;
   dic_state_t state_d [NCH];
   logic [DATA_W-1:0] rd_mux;
   logic wr_chan;
   logic [2:0] wr_ch;
   logic [2:0] wr_fld;
   logic [NCH-1:0] clr_ch;

   dic_tick_gen #(
      .MS_CNT(MS_CNT),
      .CYC_MS(CYC_MS)
   ) u_tick (
      .core_clk(core_clk),
      .rst(rst),
      .ms_tick(ms_tick),
      .cycle_tick(cycle_tick)
   );

   assign wr_chan = reg_wr && is_chan(reg_addr);
   assign wr_ch = ch_of(reg_addr);
   assign wr_fld = fld_of(reg_addr);

   // Polarity and alternating supply option, per channel
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pol_q <= '0;
         ac_q <= '0;
      end else if (wr_chan && wr_fld == FLD_CFG) begin
         pol_q[wr_ch] <= reg_wdata[CFG_POL_BIT];
         ac_q[wr_ch] <= reg_wdata[CFG_AC_BIT];
      end
   end

   // On and off levels, each channel held separately
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int c = 0; c < NCH; c++) begin
            on_lvl_q[c] <= ON_LVL_RST;
            off_lvl_q[c] <= OFF_LVL_RST;
         end
      end else if (wr_chan && wr_fld == FLD_ON_LVL) begin
         on_lvl_q[wr_ch] <= reg_wdata[LVL_W-1:0];
      end else if (wr_chan && wr_fld == FLD_OFF_LVL) begin
         off_lvl_q[wr_ch] <= reg_wdata[LVL_W-1:0];
      end
   end

   // Activation and drop-off delays in milliseconds
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int c = 0; c < NCH; c++) begin
            on_dly_q[c] <= DLY_RST;
            off_dly_q[c] <= DLY_RST;
         end
      end else if (wr_chan && wr_fld == FLD_ON_DLY) begin
         on_dly_q[wr_ch] <= reg_wdata[DLY_W-1:0];
      end else if (wr_chan && wr_fld == FLD_OFF_DLY) begin
         off_dly_q[wr_ch] <= reg_wdata[DLY_W-1:0];
      end
   end

   // Module channel base
   always_ff @(posedge core_clk) begin
      if (rst) begin
         chan_base_q <= '0;
      end else if (reg_wr && reg_addr == CHAN_BASE_ADDR) begin
         chan_base_q <= reg_wdata[BASE_W-1:0];
      end
   end

   // Threshold compare with hysteresis, then polarity
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         logic [V_W-1:0] vin;
         logic [V_W-1:0] off_mv;
         vin = input_channel_n_mv[c*V_W +: V_W];
         off_mv = ac_q[c] ? ac_off_mv(on_lvl_q[c]) : lvl_to_mv(off_lvl_q[c]);
         if (vin > lvl_to_mv(on_lvl_q[c])) begin
            energ_d[c] = 1'b1;
         end else if (vin < off_mv) begin
            energ_d[c] = 1'b0;
         end else begin
            energ_d[c] = energ_q[c];
         end
         tgt_d[c] = energ_d[c] ^ pol_q[c];
      end
   end

   // Energized state of all eight channels, sampled once per program cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         energ_q <= '0;
      end else if (cycle_tick) begin
         energ_q <= energ_d;
      end
   end

   // Present voltage, captured with the same sample
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int c = 0; c < NCH; c++) begin
            volt_q[c] <= '0;
         end
      end else if (cycle_tick) begin
         for (int c = 0; c < NCH; c++) begin
            volt_q[c] <= input_channel_n_mv[c*V_W +: V_W];
         end
      end
   end

   // Status change decisions per channel
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         logic [DLY_W:0] off_need;
         off_need = {1'b0, off_dly_q[c]} + (ac_q[c] ? (DLY_W+1)'(AC_EXTRA_MS) : '0);
         go_on[c] = 1'b0;
         go_off[c] = 1'b0;
         state_d[c] = state_q[c];
         unique case (state_q[c])
            ST_STEADY: begin
               if (tgt_d[c] && !input_channel_n[c]) begin
                  if (on_dly_q[c] == '0) begin
                     go_on[c] = 1'b1;
                  end else begin
                     state_d[c] = ST_WAIT_ON;
                  end
               end else if (!tgt_d[c] && input_channel_n[c]) begin
                  if (off_need == '0) begin
                     go_off[c] = 1'b1;
                  end else begin
                     state_d[c] = ST_WAIT_OFF;
                  end
               end
            end
            ST_WAIT_ON: begin
               if (!tgt_d[c]) begin
                  state_d[c] = ST_STEADY;
               end else if (pend_q[c] >= {1'b0, on_dly_q[c]}) begin
                  go_on[c] = 1'b1;
                  state_d[c] = ST_STEADY;
               end
            end
            ST_WAIT_OFF: begin
               if (tgt_d[c]) begin
                  state_d[c] = ST_STEADY;
               end else if (pend_q[c] >= off_need) begin
                  go_off[c] = 1'b1;
                  state_d[c] = ST_STEADY;
               end
            end
            default: begin
               state_d[c] = ST_STEADY;
            end
         endcase
      end
   end

   // Delay state and channel status, advanced on the program cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         input_channel_n <= '0;
         for (int c = 0; c < NCH; c++) begin
            state_q[c] <= ST_STEADY;
         end
      end else if (cycle_tick) begin
         for (int c = 0; c < NCH; c++) begin
            state_q[c] <= state_d[c];
            if (go_on[c]) begin
               input_channel_n[c] <= 1'b1;
            end else if (go_off[c]) begin
               input_channel_n[c] <= 1'b0;
            end
         end
      end
   end

   // Millisecond timers for pending changes, saturating
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int c = 0; c < NCH; c++) begin
            pend_q[c] <= '0;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (state_q[c] == ST_STEADY) begin
               pend_q[c] <= '0;
            end else if (ms_tick && pend_q[c] != '1) begin
               pend_q[c] <= pend_q[c] + 1'b1;
            end
         end
      end
   end

   // Clear command decode per channel
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         clr_ch[c] = wr_chan && wr_ch == 3'(c) && wr_fld == FLD_CLR_NUM
                     && reg_wdata[0] == CLR_CMD;
      end
   end

   // Rising change counters; a clear and a rise in the same cycle leave a count of one
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int c = 0; c < NCH; c++) begin
            count_q[c] <= '0;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (cycle_tick && go_on[c]) begin
               if (clr_ch[c]) begin
                  count_q[c] <= CNT_W'(1);
               end else begin
                  count_q[c] <= count_q[c] + 1'b1;
               end
            end else if (clr_ch[c]) begin
               count_q[c] <= '0;
            end
         end
      end
   end

   // Read multiplexer
   always_comb begin
      logic [2:0] ch;
      ch = ch_of(reg_addr);
      rd_mux = '0;
      if (is_chan(reg_addr)) begin
         unique case (fld_of(reg_addr))
            FLD_CFG: begin
               rd_mux[CFG_POL_BIT] = pol_q[ch];
               rd_mux[CFG_AC_BIT] = ac_q[ch];
            end
            FLD_ON_LVL: rd_mux[LVL_W-1:0] = on_lvl_q[ch];
            FLD_OFF_LVL: rd_mux[LVL_W-1:0] = off_lvl_q[ch];
            FLD_ON_DLY: rd_mux[DLY_W-1:0] = on_dly_q[ch];
            FLD_OFF_DLY: rd_mux[DLY_W-1:0] = off_dly_q[ch];
            FLD_COUNT: rd_mux = count_q[ch];
            FLD_CLR_NUM: rd_mux[BASE_W:0] = (BASE_W+1)'(chan_base_q) + (BASE_W+1)'(ch) + 1'b1;
            FLD_VOLT: rd_mux[V_W-1:0] = volt_q[ch];
         endcase
      end else if (reg_addr == CHAN_BASE_ADDR) begin
         rd_mux[BASE_W-1:0] = chan_base_q;
      end else if (reg_addr == STATUS_ADDR) begin
         rd_mux[NCH-1:0] = input_channel_n;
      end
   end

   // Read data stand one cycle after the strobe only
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule

// ### include/dic_pkg.sv
package dic_pkg;
   // Channel count and the two groups of four on a shared return
   localparam int NUM_CH = 8;
   localparam int GROUP_SIZE = 4;
   // Clock and time base
   localparam int CLK_PERIOD_PS = 5000;
   localparam int DELAY_STEP_US = 1000;
   localparam int MS_CLKS = DELAY_STEP_US * 1000000 / CLK_PERIOD_PS;
   localparam int PROG_CYCLE_MS = 5;
   localparam int AC_EXTRA_MS = 30;
   localparam int AC_OFF_PCT = 10;
   // Widths
   localparam int V_W = 19;
   localparam int LVL_W = 12;
   localparam int DLY_W = 21;
   localparam int CNT_W = 32;
   localparam int ADDR_W = 9;
   localparam int DATA_W = 32;
   localparam int BASE_W = 8;
   // One threshold step is 0.1 V, the voltage unit is 1 mV
   localparam int LVL_MV_PER_STEP = 100;
   // Reset values
   localparam logic [LVL_W-1:0] ON_LVL_RST = 12'h370;
   localparam logic [LVL_W-1:0] OFF_LVL_RST = 12'h258;
   localparam logic [DLY_W-1:0] DLY_RST = 21'h000000;
   localparam logic POL_NO = 1'b0;
   localparam logic POL_NC = 1'b1;
   localparam logic CLR_CMD = 1'b1;
   // Register map: per channel block, then globals
   localparam logic [ADDR_W-1:0] GLOBAL_BIT = 9'h100;
   localparam int CH_LSB = 5;
   localparam int FLD_LSB = 2;
   localparam logic [2:0] FLD_CFG = 3'h0;
   localparam logic [2:0] FLD_ON_LVL = 3'h1;
   localparam logic [2:0] FLD_OFF_LVL = 3'h2;
   localparam logic [2:0] FLD_ON_DLY = 3'h3;
   localparam logic [2:0] FLD_OFF_DLY = 3'h4;
   localparam logic [2:0] FLD_COUNT = 3'h5;
   localparam logic [2:0] FLD_CLR_NUM = 3'h6;
   localparam logic [2:0] FLD_VOLT = 3'h7;
   localparam logic [ADDR_W-1:0] CHAN_BASE_ADDR = 9'h100;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 9'h104;
   localparam int CFG_POL_BIT = 0;
   localparam int CFG_AC_BIT = 1;

   typedef enum logic [1:0] {
      ST_STEADY = 2'b00,
      ST_WAIT_ON = 2'b01,
      ST_WAIT_OFF = 2'b10
   } dic_state_t;
endpackage

// ### core/dic_tick_gen.sv
module dic_tick_gen
   import dic_pkg::*;
#(
   parameter int MS_CNT = MS_CLKS,
   parameter int CYC_MS = PROG_CYCLE_MS
) (
   input wire logic core_clk,
   input wire logic rst,
   output logic ms_tick,
   output logic cycle_tick
);
   logic [31:0] clk_cnt_q;
   logic [7:0] ms_cnt_q;

   // One-cycle enable every millisecond
   always_ff @(posedge core_clk) begin
      if (rst) begin
         clk_cnt_q <= 32'h0;
         ms_tick <= 1'b0;
      end else if (clk_cnt_q == 32'(MS_CNT - 1)) begin
         clk_cnt_q <= 32'h0;
         ms_tick <= 1'b1;
      end else begin
         clk_cnt_q <= clk_cnt_q + 32'h1;
         ms_tick <= 1'b0;
      end
   end

   // Program cycle enable, once every CYC_MS milliseconds
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ms_cnt_q <= 8'h0;
         cycle_tick <= 1'b0;
      end else if (ms_tick && ms_cnt_q == 8'(CYC_MS - 1)) begin
         ms_cnt_q <= 8'h0;
         cycle_tick <= 1'b1;
      end else begin
         if (ms_tick) begin
            ms_cnt_q <= ms_cnt_q + 8'h1;
         end
         cycle_tick <= 1'b0;
      end
   end
endmodule

// ### sim/dic_field_model.sv
// Field side: one contact voltage per channel, in mV, changed just after a clock edge
module dic_field_model
   import dic_pkg::*;
(
   input wire logic core_clk,
   output logic [NUM_CH*V_W-1:0] input_channel_n_mv
);
   timeunit 1ns;
   timeprecision 1ps;

   initial input_channel_n_mv = '0;

   task automatic set_mv(int c, logic [V_W-1:0] v);
      @(posedge core_clk);
      input_channel_n_mv[c*V_W +: V_W] <= v;
   endtask
endmodule

// ### sim/dic_input_conditioner_asserts.sv
module dic_input_conditioner_asserts
   import dic_pkg::*;
#(
   parameter int NCH = NUM_CH,
   parameter int MS_CNT = MS_CLKS,
   parameter int CYC_MS = PROG_CYCLE_MS
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [NCH*V_W-1:0] input_channel_n_mv,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic [NCH-1:0] input_channel_n
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PER = MS_CNT * CYC_MS;
   logic [DATA_W-1:0] sh_q [NCH][5];
   logic [DATA_W-1:0] exp_q;
   logic [DATA_W-1:0] msk;
   logic [7:0] base_q;
   logic fld_ok;
   int since_q;

   // Shadow of the settings fields, with their reset values
   assign fld_ok = !reg_addr[8] && reg_addr[1:0] == 2'h0 && reg_addr[4:2] <= FLD_OFF_DLY;
   always_comb begin
      case (reg_addr[4:2])
         FLD_CFG: msk = 32'h3;
         FLD_ON_LVL, FLD_OFF_LVL: msk = 32'hFFF;
         default: msk = 32'h1FFFFF;
      endcase
   end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int c = 0; c < NCH; c++) begin
            sh_q[c] <= '{32'h0, 32'(ON_LVL_RST), 32'(OFF_LVL_RST), 32'h0, 32'h0};
         end
      end else if (reg_wr && fld_ok) begin
         sh_q[reg_addr[7:5]][reg_addr[4:2]] <= reg_wdata & msk;
      end
   end
   always_ff @(posedge core_clk) begin
      exp_q <= sh_q[reg_addr[7:5]][reg_addr[4:2]];
   end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         base_q <= 8'h00;
      end else if (reg_wr && reg_addr == CHAN_BASE_ADDR) begin
         base_q <= reg_wdata[7:0];
      end
   end
   // Cycles since the status last moved
   always_ff @(posedge core_clk) begin
      if (rst) begin
         since_q <= 0;
      end else if ($changed(input_channel_n)) begin
         since_q <= 0;
      end else if (since_q < PER) begin
         since_q <= since_q + 1;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == '0)
      else $error("read data not zero outside a read answer");
   AST_STATUS_READ: assert property (
      reg_rd && reg_addr == STATUS_ADDR |=> reg_rdata == DATA_W'($past(input_channel_n)))
      else $error("status read differs from status pins");
   AST_STATUS_SPACING: assert property ($changed(input_channel_n) |-> since_q >= PER - 1)
      else $error("status moved between program cycles");
   AST_STATUS_RST: assert property ($fell(rst) |-> (input_channel_n == '0) [*8])
      else $error("status not idle after reset");
   AST_GLOBAL_NUM: assert property (
      reg_rd && !reg_addr[8] && reg_addr[4:0] == 5'h18 |=>
      reg_rdata == 32'($past(base_q)) + 32'($past(reg_addr[7:5])) + 32'h1)
      else $error("global channel number wrong");
   AST_CFG_READBACK: assert property (reg_rd && fld_ok |=> reg_rdata == exp_q)
      else $error("setting readback wrong");
   AST_COUNT_CLEAR: assert property (
      reg_wr && !reg_addr[8] && reg_addr[4:0] == 5'h18 && reg_wdata[0] ##2
      reg_rd && reg_addr == $past(reg_addr, 2) - 9'h4 |=> reg_rdata == '0)
      else $error("counter not zero after clear");
   AST_UNMAPPED_ZERO: assert property (
      reg_rd && reg_addr[8] && reg_addr[1:0] == 2'h0 && reg_addr > STATUS_ADDR |=> reg_rdata == '0)
      else $error("unmapped read not zero");
endmodule

bind dic_input_conditioner dic_input_conditioner_asserts #(
   .NCH(NCH), .MS_CNT(MS_CNT), .CYC_MS(CYC_MS)
) u_dic_input_conditioner_asserts (
   .core_clk(core_clk), .rst(rst), .input_channel_n_mv(input_channel_n_mv),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .input_channel_n(input_channel_n)
);

// ### sim/tb_dic_input_conditioner.sv
module tb_dic_input_conditioner;
   import dic_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MSC = 10;
   localparam int PER = MSC * PROG_CYCLE_MS;
   logic core_clk, rst, reg_wr, reg_rd;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata;
   logic [NUM_CH*V_W-1:0] mv;
   logic [NUM_CH-1:0] input_channel_n, exp_st;
   int n_mismatch = 0;
   int total_checks = 0;

   dic_field_model u_dic_field_model (.core_clk(core_clk), .input_channel_n_mv(mv));
   dic_input_conditioner #(.MS_CNT(MSC)) u_dic_input_conditioner (
      .core_clk(core_clk), .rst(rst), .input_channel_n_mv(mv), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .input_channel_n(input_channel_n));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk_pins(logic [NUM_CH-1:0] e);
      total_checks++;
      if (input_channel_n !== e) begin
         n_mismatch++;
         $display("MISMATCH status pins expected %h seen %h", e, input_channel_n);
      end
   endtask
   task automatic chk(string nm, logic [DATA_W-1:0] e, logic [DATA_W-1:0] g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rchk(string nm, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(nm, e, reg_rdata);
   endtask
   function automatic logic [ADDR_W-1:0] ca(int c, logic [2:0] f);
      return ADDR_W'(c * 32) | ADDR_W'({f, 2'b00});
   endfunction
   // Drive a voltage, wait, then compare status by read and at the pins
   task automatic sv(int c, int v, int w, logic e);
      u_dic_field_model.set_mv(c, V_W'(v));
      cyc(w);
      exp_st[c] = e;
      rchk("status reg", STATUS_ADDR, DATA_W'(exp_st));
      chk_pins(exp_st);
   endtask

   task automatic s_defaults;
      rchk("cfg", ca(0, FLD_CFG), 32'h0);
      rchk("on level", ca(0, FLD_ON_LVL), 32'h370);
      rchk("off level", ca(0, FLD_OFF_LVL), 32'h258);
      rchk("on delay", ca(0, FLD_ON_DLY), 32'h0);
      rchk("off delay", ca(0, FLD_OFF_DLY), 32'h0);
      rchk("count", ca(0, FLD_COUNT), 32'h0);
      wr(CHAN_BASE_ADDR, 32'h10);
      rchk("chan num", ca(7, FLD_CLR_NUM), 32'h18);
      rchk("unmapped", 9'h108, 32'h0);
   endtask
   task automatic s_open;
      sv(0, 90000, PER + 5, 1'b1);
      sv(0, 70000, 2 * PER, 1'b1);
      sv(0, 59999, PER + 5, 1'b0);
      rchk("count", ca(0, FLD_COUNT), 32'h1);
      rchk("volt", ca(0, FLD_VOLT), 32'd59999);
   endtask
   task automatic s_closed;
      wr(ca(1, FLD_CFG), 32'h1);
      sv(1, 0, PER + 5, 1'b1);
      sv(1, 90000, PER + 5, 1'b0);
   endtask
   task automatic s_levels;
      wr(ca(2, FLD_ON_LVL), 32'd100);
      wr(ca(2, FLD_OFF_LVL), 32'd50);
      u_dic_field_model.set_mv(7, V_W'(20000));
      sv(2, 20000, PER + 5, 1'b1);
   endtask
   task automatic s_delay;
      wr(ca(4, FLD_ON_DLY), 32'd20);
      wr(ca(4, FLD_OFF_DLY), 32'd10);
      sv(4, 90000, 2 * PER, 1'b0);
      sv(4, 90000, 5 * PER, 1'b1);
      sv(4, 0, PER, 1'b1);
      sv(4, 0, 3 * PER, 1'b0);
   endtask
   task automatic s_ac;
      wr(ca(5, FLD_CFG), 32'h2);
      sv(5, 90000, PER + 5, 1'b1);
      sv(5, 50000, 9 * PER, 1'b1);
      sv(5, 5000, 3 * PER, 1'b1);
      sv(5, 5000, 6 * PER, 1'b0);
   endtask
   task automatic s_clear;
      wr(ca(0, FLD_CLR_NUM), 32'h0);
      rchk("count kept", ca(0, FLD_COUNT), 32'h1);
      wr(ca(0, FLD_CLR_NUM), 32'h1);
      rchk("count cleared", ca(0, FLD_COUNT), 32'h0);
   endtask

   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      exp_st = '0;
      cyc(5);
      rst <= 1'b0;
      s_defaults();
      s_open();
      s_closed();
      s_levels();
      s_delay();
      s_ac();
      s_clear();
      end_of_test();
   end
   initial begin
      cyc(20000);
      n_mismatch++;
      end_of_test();
   end
endmodule
